/* File: rsme_defines.vh */
// shared constants for the receiver status message encoder
`ifndef RSME_DEFINES_VH
`define RSME_DEFINES_VH
// ----------------------------------------
// frame envelope
// ----------------------------------------
`define RSME_START0 8'ha0
`define RSME_START1 8'ha2
`define RSME_END0 8'hb0
`define RSME_END1 8'hb3
`define RSME_HDR_BYTES 3'h4
`define RSME_TRL_BYTES 3'h4
// ----------------------------------------
// message identifiers and lengths
// ----------------------------------------
`define RSME_ID_TPUT 8'h09
`define RSME_ID_ACK 8'h0b
`define RSME_ID_NACK 8'h0c
`define RSME_ID_VIS 8'h0d
`define RSME_ID_ALM 8'h0e
`define RSME_LEN_TPUT 16'h0009
`define RSME_LEN_ACK 16'h0002
`define RSME_LEN_ALM 16'h001e
`define RSME_VIS_HDR 16'h0002
`define RSME_VIS_ENTRY 16'h0005
`define RSME_VIS_MAX 4'hc
`define RSME_ALM_PAD 5'h00
// ----------------------------------------
// timing
// ----------------------------------------
`define RSME_CLK_HZ 32'd20000000
`define RSME_TPUT_PERIOD_S 32'd1
`define RSME_VIS_PERIOD_S 32'd120
`define RSME_TPUT_CYCLES (`RSME_CLK_HZ * `RSME_TPUT_PERIOD_S)
`define RSME_VIS_CYCLES (`RSME_CLK_HZ * `RSME_VIS_PERIOD_S)
// ----------------------------------------
// output buffer
// ----------------------------------------
`define RSME_FIFO_W 8
`define RSME_FIFO_D 16
`define RSME_FIFO_AW 4
`endif

/* File: rsme_encoder.v */
// receiver status message framer with its output byte fifo
`timescale 1ns/10ps
`include "rsme_defines.vh"

// ----------------------------------------
// byte fifo
// ----------------------------------------
module rsme_fifo #(
   parameter W = 8,
   parameter D = 16,
   parameter AW = 4
) (
   input wire clk_sys_i,
   input wire rst_i,
   input wire in_valid_i,
   output wire in_ready_o,
   input wire [W-1:0] in_data_i,
   output wire out_valid_o,
   input wire out_ready_i,
   output wire [W-1:0] out_data_o
);
   reg [W-1:0] mem [0:D-1];
   reg [AW-1:0] wr_q;
   reg [AW-1:0] rd_q;
   reg [AW:0] cnt_q;
   wire push;
   wire pop;
   assign in_ready_o = (cnt_q != D);
   assign out_valid_o = (cnt_q != 0);
   assign out_data_o = mem[rd_q];
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;
   always @(posedge clk_sys_i) begin
      if (push) begin
         mem[wr_q] <= in_data_i;
      end
   end
   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         wr_q <= {AW{1'b0}};
         rd_q <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule
// ----------------------------------------
// framer
// ----------------------------------------
module rsme_encoder #(
   parameter [31:0] TPUT_CYCLES = `RSME_TPUT_CYCLES,
   parameter [31:0] VIS_CYCLES = `RSME_VIS_CYCLES
) (
   input wire clk_sys_i,
   input wire rst_i,
   input wire [15:0] max_segment_duration_i,
   input wire [15:0] segment_latency_i,
   input wire [15:0] mean_tracking_time_i,
   input wire [15:0] final_millisecond_count_i,
   input wire cmd_valid_i,
   input wire cmd_accept_i,
   input wire [7:0] cmd_id_i,
   output wire cmd_ready_o,
   input wire vis_wr_i,
   input wire [3:0] vis_idx_i,
   input wire [7:0] vis_sat_i,
   input wire [15:0] vis_az_i,
   input wire [15:0] vis_el_i,
   input wire [3:0] vis_count_i,
   input wire alm_valid_i,
   input wire [7:0] satellite_number_i,
   input wire [9:0] alm_week_i,
   input wire [191:0] alm_data_i,
   output wire alm_ready_o,
   output wire out_valid_o,
   input wire out_ready_i,
   output wire [7:0] out_data_o
);
   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_HDR = 2'h1;
   localparam [1:0] ST_PAY = 2'h2;
   localparam [1:0] ST_TRL = 2'h3;
   localparam [1:0] K_FIX = 2'h0;
   localparam [1:0] K_VIS = 2'h1;
   reg [1:0] st_q;
   reg [1:0] kind_q;
   reg [15:0] len_q;
   reg [15:0] pos_q;
   reg [14:0] chk_q;
   reg [239:0] pay_q;
   reg [3:0] ent_q;
   reg [2:0] fld_q;
   reg [31:0] tput_tmr_q;
   reg [31:0] vis_tmr_q;
   reg tput_pend_q;
   reg vis_pend_q;
   reg [3:0] vis_cnt_q;
   reg [7:0] vis_sat [0:11];
   reg [15:0] vis_az [0:11];
   reg [15:0] vis_el [0:11];
   reg [7:0] byte_d;
   wire fifo_ready;
   wire fire;
   wire idle;
   wire tput_tick;
   wire vis_tick;
   wire start_cmd;
   wire start_tput;
   wire start_vis;
   wire start_alm;
   wire [15:0] alm_word1;
   wire [15:0] alm_sum;
   // sum of 13 half-words packed msb first
   function [15:0] hw_sum;
      input [207:0] v;
      integer i;
      reg [15:0] s;
      begin
         s = 16'h0000;
         for (i = 0; i < 13; i = i + 1) begin
            s = s + v[207-16*i -: 16];
         end
         hw_sum = s;
      end
   endfunction
   assign idle = (st_q == ST_IDLE);
   assign fire = !idle & fifo_ready;
   // fixed priority: replies first so a host waiting on an answer is not held up
   assign start_cmd = idle & cmd_valid_i;
   assign start_tput = idle & !cmd_valid_i & tput_pend_q;
   assign start_vis = idle & !cmd_valid_i & !tput_pend_q & vis_pend_q;
   assign start_alm = idle & !cmd_valid_i & !tput_pend_q & !vis_pend_q & alm_valid_i;
   assign cmd_ready_o = idle;
   assign alm_ready_o = idle & !cmd_valid_i & !tput_pend_q & !vis_pend_q;
   assign tput_tick = (tput_tmr_q == TPUT_CYCLES - 32'd1);
   assign vis_tick = (vis_tmr_q == VIS_CYCLES - 32'd1);
   assign alm_word1 = {alm_week_i, `RSME_ALM_PAD, 1'b1};
   assign alm_sum = hw_sum({alm_word1, alm_data_i});
   // periodic timers; the almanac check above covers week word and body, not id or satellite
   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         tput_tmr_q <= 32'h00000000;
         vis_tmr_q <= 32'h00000000;
         tput_pend_q <= 1'b0;
         vis_pend_q <= 1'b0;
      end else begin
         tput_tmr_q <= tput_tick ? 32'h00000000 : tput_tmr_q + 32'd1;
         vis_tmr_q <= vis_tick ? 32'h00000000 : vis_tmr_q + 32'd1;
         // a tick landing on the start cycle re-arms the request
         tput_pend_q <= tput_tick | (tput_pend_q & !start_tput);
         vis_pend_q <= vis_tick | (vis_pend_q & !start_vis);
      end
   end
   always @(posedge clk_sys_i) begin
      if (vis_wr_i && vis_idx_i < `RSME_VIS_MAX) begin
         vis_sat[vis_idx_i] <= vis_sat_i;
         vis_az[vis_idx_i] <= vis_az_i;
         vis_el[vis_idx_i] <= vis_el_i;
      end
   end
   // entries changed during a send go out mixed; writers should update between lists
   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         vis_cnt_q <= 4'h0;
      end else if (vis_wr_i) begin
         vis_cnt_q <= (vis_count_i > `RSME_VIS_MAX) ? `RSME_VIS_MAX : vis_count_i;
      end
   end
   always @* begin
      byte_d = 8'h00;
      case (st_q)
         ST_HDR: begin
            case (pos_q[1:0])
               2'h0: byte_d = `RSME_START0;
               2'h1: byte_d = `RSME_START1;
               2'h2: byte_d = len_q[15:8];
               default: byte_d = len_q[7:0];
            endcase
         end
         ST_PAY: begin
            if (kind_q == K_VIS) begin
               if (pos_q == 16'h0000) begin
                  byte_d = `RSME_ID_VIS;
               end else if (pos_q == 16'h0001) begin
                  byte_d = {4'h0, vis_cnt_q};
               end else begin
                  case (fld_q)
                     3'h0: byte_d = vis_sat[ent_q];
                     3'h1: byte_d = vis_az[ent_q][15:8];
                     3'h2: byte_d = vis_az[ent_q][7:0];
                     3'h3: byte_d = vis_el[ent_q][15:8];
                     default: byte_d = vis_el[ent_q][7:0];
                  endcase
               end
            end else begin
               byte_d = pay_q[239:232];
            end
         end
         ST_TRL: begin
            case (pos_q[1:0])
               2'h0: byte_d = {1'b0, chk_q[14:8]};
               2'h1: byte_d = chk_q[7:0];
               2'h2: byte_d = `RSME_END0;
               default: byte_d = `RSME_END1;
            endcase
         end
         default: byte_d = 8'h00;
      endcase
   end
   // ----------------------------------------
   // frame sequencer
   // ----------------------------------------
   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         st_q <= ST_IDLE;
         kind_q <= K_FIX;
         len_q <= 16'h0000;
         pos_q <= 16'h0000;
         chk_q <= 15'h0000;
         pay_q <= 240'h0;
         ent_q <= 4'h0;
         fld_q <= 3'h0;
      end else begin
         case (st_q)
            ST_IDLE: begin
               pos_q <= 16'h0000;
               chk_q <= 15'h0000;
               ent_q <= 4'h0;
               fld_q <= 3'h0;
               kind_q <= K_FIX;
               if (start_cmd) begin
                  st_q <= ST_HDR;
                  len_q <= `RSME_LEN_ACK;
                  pay_q <= {(cmd_accept_i ? `RSME_ID_ACK : `RSME_ID_NACK),
                            cmd_id_i, 224'h0};
               end else if (start_tput) begin
                  st_q <= ST_HDR;
                  len_q <= `RSME_LEN_TPUT;
                  // first three fields arrive already scaled by 186
                  pay_q <= {`RSME_ID_TPUT, max_segment_duration_i, segment_latency_i,
                            mean_tracking_time_i, final_millisecond_count_i, 168'h0};
               end else if (start_vis) begin
                  st_q <= ST_HDR;
                  kind_q <= K_VIS;
                  len_q <= `RSME_VIS_HDR + `RSME_VIS_ENTRY * {12'h000, vis_cnt_q};
               end else if (start_alm) begin
                  st_q <= ST_HDR;
                  len_q <= `RSME_LEN_ALM;
                  pay_q <= {`RSME_ID_ALM, satellite_number_i, alm_word1,
                            alm_data_i, alm_sum};
               end
            end
            ST_HDR: begin
               if (fire) begin
                  pos_q <= (pos_q == {13'h0, `RSME_HDR_BYTES} - 16'h1) ? 16'h0000
                           : pos_q + 16'h1;
                  if (pos_q == {13'h0, `RSME_HDR_BYTES} - 16'h1) begin
                     st_q <= (len_q == 16'h0000) ? ST_TRL : ST_PAY;
                  end
               end
            end
            ST_PAY: begin
               if (fire) begin
                  chk_q <= chk_q + {7'h00, byte_d};
                  pay_q <= {pay_q[231:0], 8'h00};
                  if (kind_q == K_VIS && pos_q > 16'h0001) begin
                     fld_q <= (fld_q == 3'h4) ? 3'h0 : fld_q + 3'h1;
                     if (fld_q == 3'h4) begin
                        ent_q <= ent_q + 4'h1;
                     end
                  end
                  if (pos_q == len_q - 16'h1) begin
                     st_q <= ST_TRL;
                     pos_q <= 16'h0000;
                  end else begin
                     pos_q <= pos_q + 16'h1;
                  end
               end
            end
            ST_TRL: begin
               if (fire) begin
                  if (pos_q == {13'h0, `RSME_TRL_BYTES} - 16'h1) begin
                     st_q <= ST_IDLE;
                     pos_q <= 16'h0000;
                  end else begin
                     pos_q <= pos_q + 16'h1;
                  end
               end
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end
   // output buffer; a stalled line backs up into the sequencer
   rsme_fifo #(
      .W(`RSME_FIFO_W),
      .D(`RSME_FIFO_D),
      .AW(`RSME_FIFO_AW)
   ) u_fifo (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .in_valid_i(!idle),
      .in_ready_o(fifo_ready),
      .in_data_i(byte_d),
      .out_valid_o(out_valid_o),
      .out_ready_i(out_ready_i),
      .out_data_o(out_data_o)
   );
endmodule

/* File: rsme_encoder_properties.sv */
// port checker for the status message encoder, bound below
`timescale 1ns/10ps
// ------
// checker
// ------
module rsme_encoder_properties (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic cmd_valid_i,
   input wire logic cmd_ready_o,
   input wire logic out_valid_o,
   input wire logic out_ready_i,
   input wire logic [7:0] out_data_o
);
   logic [15:0] pos_q;
   logic [15:0] len_q;
   logic acc;
   logic last;
   assign acc = out_valid_o && out_ready_i;
   assign last = pos_q > 16'h0003 && pos_q == len_q + 16'h0007;
   // frame position rebuilt from the stream alone, so stalls cannot fool it
   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         pos_q <= 16'h0000;
         len_q <= 16'h0000;
      end else if (acc) begin
         pos_q <= last ? 16'h0000 : pos_q + 16'h0001;
         if (pos_q == 16'h0002) len_q <= {out_data_o, 8'h00};
         if (pos_q == 16'h0003) len_q <= {len_q[15:8], out_data_o};
      end
   end
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   sequence s_take;
      cmd_valid_i && cmd_ready_o;
   endsequence
   sequence s_first;
      ##2 out_valid_o && out_data_o == 8'ha0;
   endsequence
   property p_first;
      s_take ##0 !out_valid_o |-> s_first;
   endproperty
   a_first: assert property (p_first) else $error("reply start late");
   property p_busy;
      s_take |=> !cmd_ready_o [*8];
   endproperty
   a_busy: assert property (p_busy) else $error("ready during frame");
   property p_sof0;
      acc && pos_q == 16'h0000 |-> out_data_o == 8'ha0;
   endproperty
   a_sof0: assert property (p_sof0) else $error("bad first start byte");
   property p_sof1;
      acc && pos_q == 16'h0001 |-> out_data_o == 8'ha2;
   endproperty
   a_sof1: assert property (p_sof1) else $error("bad second start byte");
   property p_eof0;
      acc && pos_q > 16'h0003 && pos_q == len_q + 16'h0006 |-> out_data_o == 8'hb0;
   endproperty
   a_eof0: assert property (p_eof0) else $error("bad first end byte");
   property p_eof;
      acc && last |-> out_data_o == 8'hb3;
   endproperty
   a_eof: assert property (p_eof) else $error("bad end byte");
   property p_len_ack;
      acc && pos_q == 16'h0004 && out_data_o inside {8'h0b, 8'h0c} |-> len_q == 16'h0002;
   endproperty
   a_len_ack: assert property (p_len_ack) else $error("bad reply length");
   property p_len_vis;
      acc && pos_q == 16'h0004 && out_data_o == 8'h0d |-> len_q <= 16'h003e;
   endproperty
   a_len_vis: assert property (p_len_vis) else $error("visible list too long");
   property p_hold;
      out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o);
   endproperty
   a_hold: assert property (p_hold) else $error("byte lost in stall");
endmodule
bind rsme_encoder rsme_encoder_properties chk (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
   .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .out_valid_o(out_valid_o),
   .out_ready_i(out_ready_i), .out_data_o(out_data_o));

/* File: rsme_host.sv */
// host model that reads, checks and keeps the last good frame
`timescale 1ns/10ps
// ------
// host
// ------
module rsme_host (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic valid_i,
   input wire logic [7:0] data_i,
   input wire logic stall_i,
   output logic ready_o
);
   logic [7:0] buf_q [0:63];
   logic [7:0] pl [0:63];
   logic [7:0] chkh;
   logic [14:0] sum;
   int pos, len, plen, nfr, nbad;
   initial ready_o = 1'b0;
   // ready moves just after an edge only
   always @(posedge clk_sys_i) ready_o <= !stall_i;
   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         pos = 0;
         nfr = 0;
         nbad = 0;
      end else if (valid_i && ready_o) begin
         if (pos == 2) len = {data_i, 8'h00};
         if (pos == 3) len = len + data_i;
         if (pos == 3) sum = 15'h0000;
         if (pos > 3 && pos < len + 4) begin
            buf_q[pos - 4] = data_i;
            sum = sum + 15'(data_i);
         end
         if (pos == len + 4) chkh = data_i;
         // a frame with a wrong sum is dropped, as a real host would
         if (pos == len + 5 && {chkh, data_i} === {1'b0, sum}) begin
            pl = buf_q;
            plen = len;
            nfr++;
         end else if (pos == len + 5) nbad++;
         pos = (pos > 3 && pos == len + 7) ? 0 : pos + 1;
      end
   end
endmodule

/* File: rsme_encoder_test.sv */
// self-checking bench for the status message encoder
`timescale 1ns/10ps
// ------
// bench
// ------
module rsme_encoder_test;
   logic clk_sys_i = 1'b0, rst_i = 1'b1, stall = 1'b0;
   logic [63:0] tf = 64'h003b_0011_0016_01e5;
   wire [15:0] max_segment_duration_i = tf[63:48];
   wire [15:0] segment_latency_i = tf[47:32];
   wire [15:0] mean_tracking_time_i = tf[31:16];
   wire [15:0] final_millisecond_count_i = tf[15:0];
   logic cmd_valid_i = 1'b0, cmd_accept_i = 1'b0, vis_wr_i = 1'b0, alm_valid_i = 1'b0;
   logic [7:0] cmd_id_i = 8'h00, vis_sat_i = 8'h00, satellite_number_i = 8'h00;
   logic [3:0] vis_idx_i = 4'h0, vis_count_i = 4'h0;
   logic [15:0] vis_az_i = 16'h0000, vis_el_i = 16'h0000;
   logic [9:0] alm_week_i = 10'h000;
   logic [191:0] alm_data_i = 192'h0;
   logic cmd_ready_o, alm_ready_o, out_valid_o, out_ready_i;
   logic [7:0] out_data_o;
   int err_total = 0, compares = 0;
   always #25 clk_sys_i = !clk_sys_i;
   rsme_encoder #(.TPUT_CYCLES(32'd300), .VIS_CYCLES(32'd700)) dut (.*);
   rsme_host host (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .valid_i(out_valid_o),
      .data_i(out_data_o), .stall_i(stall), .ready_o(out_ready_i));
   task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic end_sim();
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic wait_frame(input logic [7:0] id);
      int n;
      n = host.nfr;
      for (int k = 0; k < 3000; k++) begin
         @(negedge clk_sys_i);
         if (host.nfr != n && host.pl[0] === id) return;
         n = host.nfr;
      end
      err_total++;
      end_sim();
   endtask
   task automatic req(input bit alm);
      if (alm) alm_valid_i = 1'b1;
      else cmd_valid_i = 1'b1;
      for (int k = 0; k < 500; k++) begin
         if ((alm ? alm_ready_o : cmd_ready_o) === 1'b1) begin
            @(negedge clk_sys_i);
            alm_valid_i = 1'b0;
            cmd_valid_i = 1'b0;
            return;
         end
         @(negedge clk_sys_i);
      end
      err_total++;
      end_sim();
   endtask
   task automatic t_tput();
      time t0;
      wait_frame(8'h09);
      t0 = $time;
      wait_frame(8'h09);
      chk("tput period", 16'(($time - t0) / 50), 16'd300);
      chk("tput len", 16'(host.plen), 16'h0009);
      for (int i = 0; i < 4; i++)
         chk("tput field", {host.pl[2*i+1], host.pl[2*i+2]}, tf[63-16*i -: 16]);
   endtask
   task automatic t_cmd();
      logic [8:0] tab [0:3] = '{9'h192, 9'h092, 9'h1a6, 9'h001};
      for (int i = 0; i < 4; i++) begin
         cmd_accept_i = tab[i][8];
         cmd_id_i = tab[i][7:0];
         req(1'b0);
         wait_frame(tab[i][8] ? 8'h0b : 8'h0c);
         chk("reply len", 16'(host.plen), 16'h0002);
         chk("reply id", {8'h00, host.pl[1]}, {8'h00, tab[i][7:0]});
      end
   endtask
   task automatic t_alm();
      logic [15:0] sum, wk;
      for (int s = 0; s < 2; s++) begin
         satellite_number_i = 8'h05 + 8'(s);
         alm_week_i = 10'h2a5 - 10'(s);
         for (int i = 0; i < 24; i++) alm_data_i[191-8*i -: 8] = 8'h40 + 8'(i * 7 + s);
         wk = {alm_week_i, 5'h00, 1'b1};
         sum = wk;
         for (int j = 0; j < 12; j++) sum = sum + alm_data_i[191-16*j -: 16];
         // first pass stalls the host so the buffer fills and refuses
         req(1'b1);
         stall = (s == 0);
         if (s == 0) begin
            repeat (80) @(negedge clk_sys_i);
            chk("full stall", {14'h0, alm_ready_o, out_valid_o}, 16'h0001);
            stall = 1'b0;
         end
         wait_frame(8'h0e);
         chk("alm len", 16'(host.plen), 16'h001e);
         chk("alm sat", {8'h00, host.pl[1]}, {8'h00, satellite_number_i});
         chk("alm week", {host.pl[2], host.pl[3]}, wk);
         for (int i = 0; i < 24; i++)
            chk("alm data", {8'h00, host.pl[4+i]}, {8'h00, alm_data_i[191-8*i -: 8]});
         chk("alm check", {host.pl[28], host.pl[29]}, sum);
      end
   endtask
   task automatic t_vis();
      for (int i = 0; i < 13; i++) begin
         vis_wr_i = 1'b1;
         vis_idx_i = 4'(i);
         vis_sat_i = 8'h20 + 8'(i);
         vis_az_i = 16'h0150 + 16'(i);
         vis_el_i = 16'h0030 + 16'(i);
         vis_count_i = 4'hd;
         @(negedge clk_sys_i);
      end
      vis_wr_i = 1'b0;
      wait_frame(8'h0d);
      chk("vis len", 16'(host.plen), 16'h003e);
      chk("vis count", {8'h00, host.pl[1]}, 16'h000c);
      for (int i = 0; i < 12; i++) begin
         chk("vis sat", {8'h00, host.pl[2+5*i]}, 16'h0020 + 16'(i));
         chk("vis az", {host.pl[3+5*i], host.pl[4+5*i]}, 16'h0150 + 16'(i));
         chk("vis el", {host.pl[5+5*i], host.pl[6+5*i]}, 16'h0030 + 16'(i));
      end
   endtask
   initial begin
      repeat (6) @(negedge clk_sys_i);
      chk("reset ready", {14'h0, cmd_ready_o, alm_ready_o}, 16'h0003);
      chk("reset valid", {15'h0, out_valid_o}, 16'h0000);
      repeat (6) @(negedge clk_sys_i);
      rst_i = 1'b0;
      t_tput();
      t_cmd();
      t_alm();
      t_vis();
      chk("bad frames", 16'(host.nbad), 16'h0000);
      end_sim();
   end
endmodule
